/* File: logic/ets_edge_shaper.sv */
// transmit carrier edge shaper with its ahb-lite register file
`timescale 1ns/1ps
`default_nettype none
module ets_edge_shaper
    import ets_pkg::*;
#(
    parameter int LUT_ADDR_W = 7
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // modulation timing, same clock domain
    input wire logic mod_in,
    input wire logic carrier_tick_in,
    input wire logic [7:0] power_amp_supply_in,
    // shaped amplitude
    output logic [7:0] amp_out,
    output logic edge_busy_out
);
    import ets_pkg::*;

    ets_cfg_s cfg_q, cfg_d;
    logic [7:0] corr_q, corr_d;
    logic [6:0] lut_addr_q, lut_addr_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] idx_q, idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    ets_state_e state_q, state_d;
    logic [4:0] k_q, k_d;
    logic half_q, half_d;
    logic [7:0] amp_q, amp_d;
    logic [7:0] lut_rdata;
    logic lut_we;
    logic acc;
    logic [7:0] acc_idx;

    // progress through the edge, 0..255, ends at 255 on the last state
    function automatic logic [7:0] progress(input logic [4:0] k,
                                            input logic [4:0] n);
        logic [12:0] num;
        logic [12:0] q;
        num = 13'(({8'h00, k} + 13'd1) * 13'd255);
        q = num / {8'h00, n};
        return q[7:0];
    endfunction

    // knee level from a 3-bit time constant, clipped to full scale
    function automatic logic [7:0] knee(input logic [2:0] tc);
        logic [11:0] kl;
        kl = 12'(({9'h000, tc} + 12'd1) * {4'h0, KNEE_STEP});
        return (kl > 12'h0ff) ? FULL_LEVEL : kl[7:0];
    endfunction

    // shape value 0..255 for one style code at progress p
    function automatic logic [7:0] shape(input logic [3:0] code,
                                         input logic [2:0] tc,
                                         input logic [7:0] p,
                                         input logic [7:0] lut,
                                         input logic [7:0] sup,
                                         input logic [7:0] corr);
        logic [7:0] kl;
        logic [7:0] y1;
        logic [7:0] y2;
        logic [15:0] t;
        logic [8:0] s;
        kl = knee(tc);
        y1 = kl >> 1;
        y2 = FULL_LEVEL - y1;
        t = 16'h0000;
        s = 9'h000;
        case (code)
            STY_LIN1: begin
                return p;
            end
            STY_LIN2: begin
                if (p < P_HALF) begin
                    t = 16'(p * kl) >> 7;
                    return t[7:0];
                end
                t = 16'((p - P_HALF) * (FULL_LEVEL - kl)) >> 7;
                return kl + t[7:0];
            end
            STY_LIN3: begin
                if (p < P_QUART) begin
                    t = 16'(p * y1) >> 6;
                    return t[7:0];
                end
                if (p < P_3QUART) begin
                    t = 16'((p - P_QUART) * (y2 - y1)) >> 7;
                    return y1 + t[7:0];
                end
                t = 16'((p - P_3QUART) * (FULL_LEVEL - y2)) >> 6;
                return y2 + t[7:0];
            end
            STY_LUT: begin
                return lut;
            end
            STY_LUT_ADAPT: begin
                t = 16'(lut * sup) >> 8;
                return t[7:0];
            end
            STY_LUT_CORR: begin
                t = 16'(lut * sup) >> 8;
                s = {1'b0, t[7:0]} + {1'b0, corr};
                return s[8] ? FULL_LEVEL : s[7:0];
            end
            // reserved codes behave as a single ramp
            default: begin
                return p;
            end
        endcase
    endfunction

    // register read view; unmapped indices read as zero
    function automatic logic [31:0] rd_mux(input logic [7:0] idx,
                                           input ets_cfg_s c,
                                           input logic [7:0] corr,
                                           input logic [6:0] la,
                                           input logic [15:0] st);
        case (idx)
            IDX_EDGE_TYPE: return {24'h000000, c.edge_type};
            IDX_EDGE_STYLE: return {24'h000000, c.edge_style};
            IDX_EDGE_COUNT: return {24'h000000, c.edge_count};
            IDX_RESID_212: return {24'h000000, c.resid};
            IDX_LUT_ADDR: return {25'h0000000, la};
            IDX_CORR: return {24'h000000, corr};
            IDX_STATUS: return {16'h0000, st};
            default: return 32'h00000000;
        endcase
    endfunction

    // live fields of the edge in progress
    logic falling;
    logic [3:0] cur_type;
    logic [2:0] cur_tc;
    logic [2:0] nxt_tc;
    logic [4:0] n_states;
    logic dbl;
    logic [7:0] span;
    logic [7:0] f;
    logic [15:0] dspan;
    logic [15:0] status;

    assign falling = (state_q == ST_FALL);
    assign cur_type = falling ?
        cfg_q.edge_type[FALL_TYPE_LSB +: 4] :
        cfg_q.edge_type[RISE_TYPE_LSB +: 4];
    assign cur_tc = falling ?
        cfg_q.edge_style[FALL_STYLE_LSB +: 3] :
        cfg_q.edge_style[RISE_STYLE_LSB +: 3];
    // table read follows the next state so its data line up with each state
    assign nxt_tc = (state_d == ST_FALL) ?
        cfg_q.edge_style[FALL_STYLE_LSB +: 3] :
        cfg_q.edge_style[RISE_STYLE_LSB +: 3];
    assign n_states = cfg_q.edge_count[4:0];
    assign dbl = cfg_q.edge_count[DOUBLE_BIT];
    assign span = FULL_LEVEL - cfg_q.resid;
    assign f = shape(cur_type, cur_tc, progress(k_q, n_states),
                     lut_rdata, power_amp_supply_in, corr_q);
    assign dspan = 16'(span * f) >> 8;
    assign status = {state_q, 3'b000, half_q, 3'b000, k_q};

    // table number is the low two bits of the style field
    ets_lut_mem #(
        .DATA_W(8),
        .ADDR_W(LUT_ADDR_W)
    ) u_lut (
        .clk_in(ref_clk_in),
        .we_in(lut_we),
        .waddr_in(lut_addr_q),
        .wdata_in(hwdata_in[7:0]),
        .raddr_in({nxt_tc[1:0], k_d}),
        .rdata_out(lut_rdata)
    );

    // bus: address phase capture, data-phase writes, reads from next view
    assign acc = hsel_in & hready_in & htrans_in[HTRANS_ACTIVE_BIT];
    assign acc_idx = (haddr_in[31:10] == 22'h000000 &&
                      haddr_in[1:0] == 2'b00) ? haddr_in[9:2] : IDX_NONE;
    assign lut_we = wr_pend_q & (idx_q == IDX_LUT_DATA);

    always_comb begin
        cfg_d = cfg_q;
        corr_d = corr_q;
        lut_addr_d = lut_addr_q;
        if (wr_pend_q) begin
            case (idx_q)
                IDX_EDGE_TYPE: cfg_d.edge_type = hwdata_in[7:0];
                IDX_EDGE_STYLE: cfg_d.edge_style = hwdata_in[7:0] & STYLE_MASK;
                IDX_EDGE_COUNT: cfg_d.edge_count = hwdata_in[7:0] & COUNT_MASK;
                IDX_RESID_212: cfg_d.resid = hwdata_in[7:0];
                IDX_LUT_ADDR: lut_addr_d = hwdata_in[6:0];
                IDX_LUT_DATA: lut_addr_d = lut_addr_q + 7'h01;
                IDX_CORR: corr_d = hwdata_in[7:0];
                default: cfg_d = cfg_q; // unmapped writes are dropped
            endcase
        end
        wr_pend_d = acc & hwrite_in;
        idx_d = acc ? acc_idx : idx_q;
        // the next view covers a write finishing in this same cycle
        hrdata_d = (acc && !hwrite_in) ?
            rd_mux(acc_idx, cfg_d, corr_d, lut_addr_d, status) : hrdata_q;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_q <= '{RST_EDGE_TYPE, RST_EDGE_STYLE, RST_EDGE_COUNT,
                       RST_RESID};
            corr_q <= RST_CORR;
            lut_addr_q <= RST_LUT_ADDR;
            wr_pend_q <= 1'b0;
            idx_q <= IDX_NONE;
            hrdata_q <= 32'h00000000;
        end else begin
            cfg_q <= cfg_d;
            corr_q <= corr_d;
            lut_addr_q <= lut_addr_d;
            wr_pend_q <= wr_pend_d;
            idx_q <= idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // shaper: an edge always completes before modulation is looked at again
    always_comb begin
        state_d = state_q;
        k_d = k_q;
        half_d = half_q;
        amp_d = amp_q;
        case (state_q)
            ST_HIGH: begin
                amp_d = FULL_LEVEL;
                if (mod_in) begin
                    k_d = 5'h00;
                    half_d = 1'b0;
                    // a zero count means a hard step
                    state_d = (n_states == 5'h00) ? ST_LOW : ST_FALL;
                end
            end
            ST_LOW: begin
                amp_d = cfg_q.resid;
                if (!mod_in) begin
                    k_d = 5'h00;
                    half_d = 1'b0;
                    state_d = (n_states == 5'h00) ? ST_HIGH : ST_RISE;
                end
            end
            ST_FALL, ST_RISE: begin
                amp_d = falling ? FULL_LEVEL - dspan[7:0] :
                                  cfg_q.resid + dspan[7:0];
                if (carrier_tick_in) begin
                    if (dbl && !half_q) begin
                        half_d = 1'b1;
                    end else begin
                        half_d = 1'b0;
                        if (k_q >= n_states - 5'h01) begin
                            k_d = 5'h00;
                            state_d = falling ? ST_LOW : ST_HIGH;
                        end else begin
                            k_d = k_q + 5'h01;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_HIGH;
                k_d = 5'h00;
                half_d = 1'b0;
                amp_d = FULL_LEVEL;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= ST_HIGH;
            k_q <= 5'h00;
            half_q <= 1'b0;
            amp_q <= FULL_LEVEL;
        end else begin
            state_q <= state_d;
            k_q <= k_d;
            half_q <= half_d;
            amp_q <= amp_d;
        end
    end

    // outputs; zero wait state slave, always okay
    assign hrdata_out = hrdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign amp_out = amp_q;
    assign edge_busy_out = (state_q == ST_FALL) | (state_q == ST_RISE);

endmodule
`default_nettype wire

/* File: logic/ets_pkg.sv */
// shared constants and types of the transmit edge shaping block
`default_nettype none
package ets_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EDGE_TYPE = 8'h55;
    localparam logic [7:0] IDX_EDGE_STYLE = 8'h56;
    localparam logic [7:0] IDX_EDGE_COUNT = 8'h57;
    localparam logic [7:0] IDX_RESID_212 = 8'h58;
    localparam logic [7:0] IDX_LUT_ADDR = 8'h60;
    localparam logic [7:0] IDX_LUT_DATA = 8'h61;
    localparam logic [7:0] IDX_CORR = 8'h62;
    localparam logic [7:0] IDX_STATUS = 8'h63;
    localparam logic [7:0] IDX_NONE = 8'h00;

    // values after reset
    localparam logic [7:0] RST_EDGE_TYPE = 8'h11;
    localparam logic [7:0] RST_EDGE_STYLE = 8'h00;
    localparam logic [7:0] RST_EDGE_COUNT = 8'h08;
    localparam logic [7:0] RST_RESID = 8'h00;
    localparam logic [7:0] RST_CORR = 8'h00;
    localparam logic [6:0] RST_LUT_ADDR = 7'h00;

    // field positions and writable-bit masks
    localparam int FALL_TYPE_LSB = 4;
    localparam int RISE_TYPE_LSB = 0;
    localparam int FALL_STYLE_LSB = 4;
    localparam int RISE_STYLE_LSB = 0;
    localparam int DOUBLE_BIT = 7;
    localparam logic [7:0] STYLE_MASK = 8'h77;
    localparam logic [7:0] COUNT_MASK = 8'h9f;

    // edge style codes
    localparam logic [3:0] STY_LIN1 = 4'h1;
    localparam logic [3:0] STY_LIN2 = 4'h2;
    localparam logic [3:0] STY_LIN3 = 4'h3;
    localparam logic [3:0] STY_LUT = 4'h4;
    localparam logic [3:0] STY_LUT_CORR = 4'h5;
    localparam logic [3:0] STY_LUT_ADAPT = 4'h6;

    // amplitude and progress scale points
    localparam logic [7:0] FULL_LEVEL = 8'hff;
    localparam logic [7:0] KNEE_STEP = 8'h20;
    localparam logic [7:0] P_QUART = 8'h40;
    localparam logic [7:0] P_HALF = 8'h80;
    localparam logic [7:0] P_3QUART = 8'hc0;

    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    typedef enum logic [3:0] {
        ST_HIGH = 4'b0001,
        ST_FALL = 4'b0010,
        ST_LOW = 4'b0100,
        ST_RISE = 4'b1000
    } ets_state_e;

    typedef struct packed {
        logic [7:0] edge_type;
        logic [7:0] edge_style;
        logic [7:0] edge_count;
        logic [7:0] resid;
    } ets_cfg_s;

endpackage
`default_nettype wire

/* File: logic/ets_lut_mem.sv */
// lookup table memory with a registered read port
`timescale 1ns/1ps
`default_nettype none
module ets_lut_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    // clock
    input wire logic clk_in,
    // write port
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] waddr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    // read port
    input wire logic [ADDR_W-1:0] raddr_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // no reset on the array; contents are software's to load
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

/* File: bench/ets_edge_shaper_chk.sv */
// port-level assertion checker for the edge shaper
`timescale 1ns/1ps
`default_nettype none
module ets_edge_shaper_chk
    import ets_pkg::*;
(
    // clock, reset and bus
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // shaper side
    input wire logic mod_in,
    input wire logic carrier_tick_in,
    input wire logic [7:0] amp_out,
    input wire logic edge_busy_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic wr_q, low_q;
    logic [7:0] widx_q, cnt_q, res_q;
    logic [6:0] tk_q;
    // shadow copies of count and level, idle side, ticks seen in an edge
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_q <= 1'b0;
            widx_q <= IDX_NONE;
            cnt_q <= RST_EDGE_COUNT;
            res_q <= RST_RESID;
            low_q <= 1'b0;
            tk_q <= 7'h00;
        end else begin
            wr_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
            widx_q <= haddr_in[9:2];
            if (wr_q && widx_q == IDX_EDGE_COUNT) cnt_q <= hwdata_in[7:0];
            if (wr_q && widx_q == IDX_RESID_212) res_q <= hwdata_in[7:0];
            // mod_in only counts while idle; a running edge ignores it
            if (!edge_busy_out && mod_in != low_q) low_q <= mod_in;
            tk_q <= edge_busy_out ? tk_q + 7'(carrier_tick_in) : 7'h00;
        end
    end
    sequence s_done;
        $fell(edge_busy_out);
    endsequence
    property p_start;
        !edge_busy_out && mod_in != low_q && cnt_q[4:0] != 5'h00
            |=> edge_busy_out;
    endproperty
    property p_hold;
        edge_busy_out && !carrier_tick_in |=> edge_busy_out;
    endproperty
    property p_tick;
        s_done |-> $past(carrier_tick_in);
    endproperty
    property p_single;
        s_done ##0 !cnt_q[7] |-> tk_q == {2'b00, cnt_q[4:0]};
    endproperty
    property p_double;
        s_done ##0 cnt_q[7] |-> tk_q == {1'b0, cnt_q[4:0], 1'b0};
    endproperty
    property p_low;
        s_done ##0 low_q |-> ##[1:2] amp_out == res_q;
    endproperty
    property p_high;
        s_done ##0 !low_q |-> ##[1:2] amp_out == FULL_LEVEL;
    endproperty
    property p_range;
        edge_busy_out |-> amp_out >= res_q;
    endproperty
    property p_bus;
        hreadyout_out && !hresp_out;
    endproperty
    a_start: assert property (p_start)
        else $error("edge did not start");
    a_hold: assert property (p_hold)
        else $error("edge ended without a tick");
    a_tick: assert property (p_tick)
        else $error("edge end not on a tick");
    a_single: assert property (p_single)
        else $error("wrong state count");
    a_double: assert property (p_double)
        else $error("wrong doubled state count");
    a_low: assert property (p_low)
        else $error("low level not residual");
    a_high: assert property (p_high)
        else $error("high level not full");
    a_range: assert property (p_range)
        else $error("amplitude below residual");
    a_bus: assert property (p_bus)
        else $error("bus not ready or not okay");
endmodule
bind ets_edge_shaper ets_edge_shaper_chk u_ets_edge_shaper_chk (
    .ref_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .mod_in,
    .carrier_tick_in, .amp_out, .edge_busy_out);
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the edge shaper
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ets_pkg::*;
    logic ref_clk_in, rst_in, hsel_in, hwrite_in, mod_in, carrier_tick_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0] htrans_in;
    logic [7:0] power_amp_supply_in, amp_out, res, sup, corr, sty, typ;
    logic [7:0] lut_m [128];
    logic [7:0] end_q[$];
    logic [4:0] n;
    logic busy_q = 1'b0;
    logic hreadyout_out, hresp_out, edge_busy_out, chk_rd, chk_amp;
    logic [31:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;
    ets_edge_shaper u_ets_edge_shaper (.ref_clk_in, .rst_in, .hsel_in,
        .haddr_in, .htrans_in, .hwrite_in, .hwdata_in,
        .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
        .mod_in, .carrier_tick_in, .power_amp_supply_in, .amp_out,
        .edge_busy_out);
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one single-word transfer; a read notes its expected data
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= {22'h0, idx, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= w;
        do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= w ? d : 32'h0;
        chk_rd <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
        chk_rd <= 1'b0;
    endtask
    // bounded wait for the busy flag; a hang counts as a mismatch
    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 400 && edge_busy_out !== v; i++)
            @(posedge ref_clk_in);
        if (i == 400) check(32'(edge_busy_out), 32'(v));
    endtask
    // amplitude at the last state of an edge, from the style choices
    function automatic logic [7:0] exp_end(input logic fall);
        logic [3:0] c;
        logic [2:0] tc;
        int kl, y1, lv, m, f;
        c = fall ? typ[7:4] : typ[3:0];
        tc = fall ? sty[6:4] : sty[2:0];
        kl = (tc + 1) * 32;
        kl = (kl > 255) ? 255 : kl;
        y1 = kl / 2;
        lv = lut_m[{tc[1:0], n - 5'h01}];
        m = lv * sup / 256;
        case (c)
            4'h2: f = kl + 127 * (255 - kl) / 128;
            4'h3: f = 255 - y1 + 63 * y1 / 64;
            4'h4: f = lv;
            4'h5: f = (m + corr > 255) ? 255 : m + corr;
            4'h6: f = m;
            default: f = 255;
        endcase
        kl = (255 - res) * f / 256;
        return fall ? 8'(255 - kl) : 8'(res + kl);
    endfunction
    // one modulation change; g flips mod_in back while the edge runs
    task automatic edge_run(input logic m, input logic g);
        end_q.push_back(exp_end(m));
        mod_in <= m;
        @(posedge ref_clk_in);
        wait_busy(1'b1);
        if (g) mod_in <= !m;
        wait_busy(1'b0);
        // the flipped request is only taken once the edge is over
        if (g) begin
            end_q.push_back(exp_end(!m));
            wait_busy(1'b1);
            wait_busy(1'b0);
        end
        repeat (3) @(posedge ref_clk_in);
        exp_q.push_back({24'h0, (m ^ g) ? res : FULL_LEVEL});
        chk_amp <= 1'b1;
        @(posedge ref_clk_in);
        chk_amp <= 1'b0;
    endtask
    // compares each noted expectation with the output it belongs to
    always @(posedge ref_clk_in) begin
        if (chk_rd && hreadyout_out) check(hrdata_out, exp_q.pop_front());
        if (chk_amp) check({24'h0, amp_out}, exp_q.pop_front());
        // last shaped value of each edge, seen as busy drops
        if (busy_q && !edge_busy_out && end_q.size() > 0)
            check({24'h0, amp_out}, {24'h0, end_q.pop_front()});
        busy_q <= edge_busy_out;
    end
    // random carrier ticks; ignored while the shaper is idle
    always @(posedge ref_clk_in) carrier_tick_in <= ($urandom % 3) == 0;
    initial begin
        int t;
        void'($urandom(33));
        {rst_in, hsel_in, hwrite_in, mod_in} = 4'b1000;
        {haddr_in, hwdata_in} = 64'h0;
        htrans_in = 2'b00;
        power_amp_supply_in = 8'hff;
        {chk_rd, chk_amp} = 2'b00;
        res = 8'h00;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        // reset values, read-zero bits and an unmapped word
        bus(0, IDX_EDGE_TYPE, RST_EDGE_TYPE);
        bus(0, IDX_EDGE_STYLE, RST_EDGE_STYLE);
        bus(0, IDX_EDGE_COUNT, RST_EDGE_COUNT);
        bus(0, IDX_RESID_212, RST_RESID);
        bus(1, IDX_EDGE_STYLE, 32'hffff_ffff);
        bus(0, IDX_EDGE_STYLE, STYLE_MASK);
        bus(1, IDX_EDGE_COUNT, 32'hff);
        bus(0, IDX_EDGE_COUNT, COUNT_MASK);
        bus(1, IDX_NONE, 32'h5a);
        bus(0, IDX_NONE, 32'h0);
        bus(0, IDX_STATUS, 32'h1000);
        // fill all four tables so table styles never read unknowns
        bus(1, IDX_LUT_ADDR, 32'h0);
        for (t = 0; t < 128; t++) begin
            lut_m[t] = 8'($urandom);
            bus(1, IDX_LUT_DATA, {24'h0, lut_m[t]});
        end
        // the address wrapped after all entries; the data word reads zero
        bus(0, IDX_LUT_ADDR, 32'h0);
        bus(0, IDX_LUT_DATA, 32'h0);
        corr = 8'($urandom);
        bus(1, IDX_CORR, {24'h0, corr});
        bus(0, IDX_CORR, {24'h0, corr});
        // every style code on each edge, counts 1 and 31 included
        for (t = 1; t <= 6; t++) begin
            res = 8'($urandom);
            sup = 8'($urandom);
            sty = 8'($urandom);
            typ = {t[3:0], 4'(7 - t)};
            n = 5'(t == 1 ? 1 : t == 6 ? 31 : 1 + $urandom % 31);
            power_amp_supply_in <= sup;
            bus(1, IDX_RESID_212, {24'h0, res});
            bus(1, IDX_EDGE_TYPE, {24'h0, typ});
            bus(1, IDX_EDGE_STYLE, {24'h0, sty});
            bus(1, IDX_EDGE_COUNT, {24'h0, t[0], 2'b00, n});
            edge_run(1'b1, 1'b0);
            edge_run(1'b0, t == 6);
        end
        stop_test();
    end
    // watchdog against a hung run
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
